// file: logic/sesr_top.v
`timescale 1ns/1ps
`include "sesr_defines.vh"

module sesr_top #(
	parameter [`WCNT_W-1:0] WRITE_CYCLES = `WRITE_TIME_NS / `CLK_PERIOD_NS
) (
	input wire CLK, // System clock, 200 MHz
	input wire RESET, // Synchronous reset, active high
	input wire CS_N, // Serial select, active low
	input wire SCK, // Serial clock from the master
	input wire SDI, // Serial data in
	input wire LOCK_N, // Status lock pin, active low
	output reg SDO, // Serial data out
	output wire SDO_OE // High while SDO is driven
);

	////////////////////////////////////////////////////////////////////////
	// State encodings
	localparam [7:0] ST_IDLE = 8'h01;
	localparam [7:0] ST_CMD = 8'h02;
	localparam [7:0] ST_WAIT = 8'h04;
	localparam [7:0] ST_STAT = 8'h08;
	localparam [7:0] ST_SDAT = 8'h10;
	localparam [7:0] ST_ADDR = 8'h20;
	localparam [7:0] ST_RDAT = 8'h40;
	localparam [7:0] ST_WDAT = 8'h80;

	////////////////////////////////////////////////////////////////////////
	// Declarations
	reg cs_m;
	reg cs_s;
	reg cs_d;
	reg sck_m;
	reg sck_s;
	reg sck_d;
	reg sdi_m;
	reg sdi_s;
	reg lk_m;
	reg lk_s;
	reg armed;
	reg [7:0] state;
	reg [3:0] cnt;
	reg [7:0] sr;
	reg [`ADDR_W-1:0] addr;
	reg is_rd;
	reg [2:0] obit;
	reg [7:0] out_byte;
	reg write_latch_flag;
	reg busy_flag;
	reg [`WCNT_W-1:0] wcnt;
	reg status_lock_bit;
	reg block_guard_hi;
	reg block_guard_lo;
	reg new_lock;
	reg [1:0] new_guard;
	reg sw_ok;
	reg wr_ok;
	reg pend_arr;
	reg [`ADDR_W-1:0] pend_addr;
	reg [7:0] pend_data;
	reg [7:0] mem [0:`MEM_TOP];
	wire sck_rise;
	wire sck_fall;
	wire cs_rise;
	wire cs_fall;
	wire [7:0] in_byte;
	wire [7:0] status_byte;
	wire hard_lock_mode;
	wire [1:0] guard;
	wire guard_hit;
	wire [`ADDR_W-1:0] addr_inc;
	wire [`ADDR_W-1:0] addr_full;
	wire cycle_end;
	wire mem_we;

	////////////////////////////////////////////////////////////////////////
	// Two-stage synchronisers for the CS_N, SCK, SDI and LOCK_N pins
	always @(posedge CLK) begin
		if (RESET) begin
			cs_m <= 1'b0;
			cs_s <= 1'b0;
			sck_m <= 1'b0;
			sck_s <= 1'b0;
			sdi_m <= 1'b0;
			sdi_s <= 1'b0;
			lk_m <= 1'b1;
			lk_s <= 1'b1;
		end else begin
			cs_m <= CS_N;
			cs_s <= cs_m;
			sck_m <= SCK;
			sck_s <= sck_m;
			sdi_m <= SDI;
			sdi_s <= sdi_m;
			lk_m <= LOCK_N;
			lk_s <= lk_m;
		end
	end

	// Edge history of synchronised select and clock
	always @(posedge CLK) begin
		if (RESET) begin
			cs_d <= 1'b0;
			sck_d <= 1'b0;
			armed <= 1'b0;
		end else begin
			cs_d <= cs_s;
			sck_d <= sck_s;
			armed <= armed | cs_s; // Select must be seen high first
		end
	end

	// Edge strobes; rise samples input, fall moves output
	assign sck_rise = sck_s & ~sck_d;
	assign sck_fall = ~sck_s & sck_d;
	assign cs_rise = cs_s & ~cs_d;
	assign cs_fall = ~cs_s & cs_d;

	////////////////////////////////////////////////////////////////////////
	// Status byte and protection decode
	assign guard = {block_guard_hi, block_guard_lo};
	assign status_byte = {status_lock_bit, `SB_RSVD_ZERO,
		guard, write_latch_flag, busy_flag};
	assign hard_lock_mode = status_lock_bit & ~lk_s;
	assign guard_hit = (guard == `BG_ALL) |
		((guard == `BG_HALF) & pend_addr[`ADDR_W-1]) |
		((guard == `BG_QUARTER) &
		(&pend_addr[`ADDR_W-1:`ADDR_W-2]));

	// Shift data helpers
	assign in_byte = {sr[6:0], sdi_s};
	assign addr_inc = addr + {{(`ADDR_W-1){1'b0}}, 1'b1};
	assign addr_full = {addr[`ADDR_W-2:0], sdi_s};
	assign cycle_end = busy_flag & (wcnt == {{(`WCNT_W-1){1'b0}}, 1'b1});
	assign mem_we = cycle_end & pend_arr;

	// Output driven only while shifting read data
	assign SDO_OE = ~cs_s & ((state == ST_STAT) | (state == ST_RDAT));

	////////////////////////////////////////////////////////////////////////
	// Array storage, written when an array cycle ends
	always @(posedge CLK) begin
		if (mem_we) begin
			mem[pend_addr] <= pend_data;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Instruction engine, write timer and status bits
	always @(posedge CLK) begin
		if (RESET) begin
			state <= ST_IDLE;
			cnt <= 4'h0;
			sr <= 8'h00;
			addr <= {`ADDR_W{1'b0}};
			is_rd <= 1'b0;
			obit <= 3'h0;
			out_byte <= 8'h00;
			SDO <= 1'b0;
			write_latch_flag <= 1'b0;
			busy_flag <= 1'b0;
			wcnt <= {`WCNT_W{1'b0}};
			status_lock_bit <= 1'b0;
			block_guard_hi <= 1'b0;
			block_guard_lo <= 1'b0;
			new_lock <= 1'b0;
			new_guard <= 2'h0;
			sw_ok <= 1'b0;
			wr_ok <= 1'b0;
			pend_arr <= 1'b0;
			pend_addr <= {`ADDR_W{1'b0}};
			pend_data <= 8'h00;
		end else begin
			// Self-timed cycle countdown
			if (busy_flag) begin
				wcnt <= wcnt - {{(`WCNT_W-1){1'b0}}, 1'b1};
			end
			if (cycle_end) begin
				busy_flag <= 1'b0;
				write_latch_flag <= 1'b0;
				if (!pend_arr) begin
					status_lock_bit <= new_lock;
					block_guard_hi <= new_guard[1];
					block_guard_lo <= new_guard[0];
				end
			end
			if (cs_s) begin
				// Deselect ends any transfer, a read included
				state <= ST_IDLE;
				sw_ok <= 1'b0;
				wr_ok <= 1'b0;
				if (cs_rise && !busy_flag && write_latch_flag) begin
					// Status write accepted unless hard-locked
					if (state == ST_SDAT && sw_ok &&
						!hard_lock_mode) begin
						busy_flag <= 1'b1;
						wcnt <= WRITE_CYCLES;
						pend_arr <= 1'b0;
					end
					// Array write accepted on a byte boundary
					if (state == ST_WDAT && wr_ok && !guard_hit) begin
						busy_flag <= 1'b1;
						wcnt <= WRITE_CYCLES;
						pend_arr <= 1'b1;
					end
				end
			end else if (cs_fall && armed) begin
				state <= ST_CMD;
				cnt <= 4'h0;
			end else if (sck_rise) begin
				case (state)
					ST_CMD: begin
						sr <= in_byte;
						cnt <= cnt + 4'h1;
						if (cnt == `LAST_BIT) begin
							cnt <= 4'h0;
							obit <= 3'h0;
							case (in_byte)
								`OP_LATCH_SET: begin
									write_latch_flag <= 1'b1;
									state <= ST_WAIT;
								end
								`OP_LATCH_CLEAR: begin
									write_latch_flag <= 1'b0;
									state <= ST_WAIT;
								end
								`OP_STATUS_READ: begin
									out_byte <= status_byte;
									state <= ST_STAT;
								end
								`OP_STATUS_WRITE: begin
									state <= busy_flag ? ST_WAIT : ST_SDAT;
								end
								`OP_ARRAY_READ: begin
									is_rd <= 1'b1;
									state <= busy_flag ? ST_WAIT : ST_ADDR;
								end
								`OP_ARRAY_WRITE: begin
									is_rd <= 1'b0;
									state <= busy_flag ? ST_WAIT : ST_ADDR;
								end
								default: begin
									state <= ST_WAIT;
								end
							endcase
						end
					end
					ST_SDAT: begin
						if (sw_ok) begin
							// A ninth edge discards the command
							sw_ok <= 1'b0;
							state <= ST_WAIT;
						end else begin
							sr <= in_byte;
							cnt <= cnt + 4'h1;
							if (cnt == `LAST_BIT) begin
								new_lock <= in_byte[`SB_LOCK];
								new_guard <= in_byte[`SB_GUARD_HI:`SB_GUARD_LO];
								sw_ok <= 1'b1;
							end
						end
					end
					ST_ADDR: begin
						addr <= addr_full;
						cnt <= cnt + 4'h1;
						if (cnt == `LAST_ADDR_BIT) begin
							cnt <= 4'h0;
							if (is_rd) begin
								out_byte <= mem[addr_full];
								state <= ST_RDAT;
							end else begin
								state <= ST_WDAT;
							end
						end
					end
					ST_WDAT: begin
						sr <= in_byte;
						cnt <= cnt + 4'h1;
						wr_ok <= 1'b0;
						if (cnt == `LAST_BIT) begin
							cnt <= 4'h0;
							pend_data <= in_byte;
							pend_addr <= addr;
							wr_ok <= 1'b1;
							// Page roll-over keeps the upper address bits
							addr[`PAGE_W-1:0] <= addr_inc[`PAGE_W-1:0];
						end
					end
					default: begin
						state <= state;
					end
				endcase
			end else if (sck_fall &&
				(state == ST_STAT || state == ST_RDAT)) begin
				// Shift out MSB first, reload every eighth bit
				SDO <= out_byte[~obit];
				obit <= obit + 3'h1;
				if (obit == `LAST_OUT_BIT) begin
					if (state == ST_RDAT) begin
						addr <= addr_inc;
						out_byte <= mem[addr_inc];
					end else begin
						out_byte <= status_byte;
					end
				end
			end
		end
	end

endmodule // sesr_top

// file: logic/sesr_defines.vh
// Operation
// - Array or status writes need the write latch already set by latch-set.
// - Latch-clear instruction clears the write latch.
// - Write latch clears at reset and when any write cycle completes.
// - After latch-set or latch-clear the device idles until deselected.
// - Status read works anytime, repeating the status byte while selected.
// - Busy flag reads 1 during a write cycle, 0 otherwise.
// - Write latch flag at 0 rejects array and status writes.
// - Block-guard bits change only by status write and guard array regions.
// - Lock bit 1 with lock pin low is hard-lock: status writes rejected.
// - Status write keeps bits 6,5,4,1,0; bits 6..4 read zero.
// - Select must rise right after the eighth data bit, else discarded.
// - Valid status write starts timed cycle; end clears busy and latch.
// - Lock and guard bits keep old values until the cycle completes.
// - Lock bit 0: status write accepted whenever the latch is set.
// - Lock bit 1 and lock pin high: status write accepted if latched.
// - Hard-lock follows the later of lock bit or pin; pin high leaves it.
// - Read: opcode, two address bytes, then addressed byte shifts out.
// - Read address increments per byte and wraps to zero at top.
// - Select rising ends a read at any point.
// - Read command is refused while a write cycle runs.
// - Decode latch-set, latch-clear, status-read; unknown codes idle until deselected.
// - Decode status-write and array-read opcodes.
// - Input sampled on clock rise, output changes on clock fall.
`ifndef SESR_DEFINES_VH
`define SESR_DEFINES_VH

// Instruction codes
`define OP_LATCH_SET 8'h06
`define OP_LATCH_CLEAR 8'h04
`define OP_STATUS_READ 8'h05
`define OP_STATUS_WRITE 8'h01
`define OP_ARRAY_READ 8'h03
`define OP_ARRAY_WRITE 8'h02

// Status byte layout
`define SB_LOCK 7
`define SB_GUARD_HI 3
`define SB_GUARD_LO 2
`define SB_RSVD_ZERO 3'h0

// Block-guard encodings
`define BG_QUARTER 2'h1
`define BG_HALF 2'h2
`define BG_ALL 2'h3

// Array geometry
`define ADDR_W 15
`define MEM_TOP 32767
`define PAGE_W 7

// Bit counts within a transfer
`define LAST_BIT 4'h7
`define LAST_ADDR_BIT 4'hf
`define LAST_OUT_BIT 3'h7

// Self-timed write length and clock period
`define WRITE_TIME_NS 1000000
`define CLK_PERIOD_NS 5
`define WCNT_W 24

`endif

// file: verif/sesr_checker.sv
`timescale 1ns/1ps
////////////////////////////////////////
// Watches the serial pins of the device
module sesr_checker #(
	parameter [23:0] WRITE_CYCLES = 24'h030d40 // Write cycle length
) (
	input wire CLK, // System clock
	input wire RESET, // Synchronous reset
	input wire CS_N, // Select, active low
	input wire SCK, // Serial clock
	input wire SDI, // Serial data in
	input wire LOCK_N, // Lock pin
	input wire SDO, // Serial data out
	input wire SDO_OE // Output enable
);
	default clocking cb @(posedge CLK); endclocking
	default disable iff (RESET);
	reg [5:0] rises;
	reg sck_d;
	// Counts clock rises within one frame
	always @(posedge CLK) begin
		sck_d <= SCK;
		if (RESET || CS_N)
			rises <= 6'h00;
		else if (SCK && !sck_d && rises != 6'h3f)
			rises <= rises + 6'h01;
	end
	a_quiet_after_reset:
		assert property ($fell(RESET) |-> !SDO_OE) else $error("oe at reset");
	a_idle_undriven:
		assert property (CS_N [*6] |-> !SDO_OE) else $error("oe unselected");
	a_oe_needs_sel:
		assert property (SDO_OE |-> !$past(CS_N, 4)) else $error("oe early");
	a_oe_drops_fast:
		assert property ($rose(CS_N) |-> ##[1:6] !SDO_OE) else $error("oe held");
	a_oe_holds:
		assert property (SDO_OE && !CS_N |=> SDO_OE) else $error("oe dropped");
	a_sdo_hold_high:
		assert property ((SCK && !CS_N) [*8] |-> $stable(SDO))
		else $error("sdo moved, clock high");
	a_sdo_hold_low:
		assert property ((!SCK && !CS_N) [*8] |-> $stable(SDO))
		else $error("sdo moved late");
	a_oe_after_op:
		assert property ($rose(SDO_OE) |-> rises >= 6'h08)
		else $error("oe before opcode");
	c_data_out: cover property ($rose(SDO_OE));
	c_cut_read: cover property (SDO_OE && $rose(CS_N));
	c_lock_pin: cover property ($fell(LOCK_N));
endmodule // sesr_checker

bind sesr_top sesr_checker #(.WRITE_CYCLES(WRITE_CYCLES)) sesr_checker_i (
	.CLK(CLK), .RESET(RESET), .CS_N(CS_N), .SCK(SCK), .SDI(SDI),
	.LOCK_N(LOCK_N), .SDO(SDO), .SDO_OE(SDO_OE));

// file: verif/sesr_spi.sv
`timescale 1ns/1ps
////////////////////////////////////////
// Serial master on the far side of the device
module sesr_spi (
	output logic cs_n, // Select, active low
	output logic sck, // Serial clock
	output logic sdi, // Data to device
	input wire logic sdo, // Data from device
	input wire logic sdo_oe // Device drives sdo
);
	logic cpol = 1'b0; // Clock idle level
	// Idle pins
	initial begin
		cs_n = 1'b1;
		sck = 1'b0;
		sdi = 1'b0;
	end
	// One frame of n bytes, MSB first; r from the last byte, oe from the last bit
	task send(input [39:0] w, input int n, output [7:0] r, output oe);
		sck = cpol;
		cs_n = 1'b0;
		#100;
		repeat (n * 8) begin
			sck = 1'b0; // Fall launches device data
			sdi = w[39];
			w = w << 1;
			#40;
			sck = 1'b1; // Rise captures on both sides
			r = {r[6:0], sdo};
			oe = sdo_oe;
			#40;
		end
		sck = cpol;
		cs_n = 1'b1; // Before the next rise
		sdi = ~sdi; // Released line shows no stale value
		#200;
	endtask
endmodule // sesr_spi

// file: verif/tb_top.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin n_errors++; \
	$display("[FAIL] %s exp %h got %h", n, e, g); end end
////////////////////////////////////////
// Device, serial master and test sequence
module tb_top;
	logic CLK = 1'b0;
	logic RESET = 1'b1;
	logic LOCK_N = 1'b1;
	wire CS_N, SCK, SDI, SDO, SDO_OE;
	int n_errors = 0;
	int checks = 0;
	int cyc = 0;
	int seed = 32'haa75;
	logic [7:0] r, a, d;
	logic oe;
	logic lk = 1'b0;
	logic lat = 1'b0;
	logic [1:0] g = 2'h0;
	// 200 MHz clock
	always #2.5 CLK = ~CLK;
	sesr_top #(.WRITE_CYCLES(24'h190)) sesr_top_i (
		.CLK(CLK), .RESET(RESET), .CS_N(CS_N), .SCK(SCK), .SDI(SDI),
		.LOCK_N(LOCK_N), .SDO(SDO), .SDO_OE(SDO_OE));
	sesr_spi sesr_spi_i (.cs_n(CS_N), .sck(SCK), .sdi(SDI), .sdo(SDO),
		.sdo_oe(SDO_OE));
	// Expected status byte from the tracked state
	function logic [7:0] es(input logic bz);
		return {lk, 3'h0, g, lat, bz};
	endfunction
	// Frame helpers
	task tx(input [39:0] w, input int n);
		sesr_spi_i.send(w, n, r, oe);
	endtask
	task status_read_cmd;
		tx({8'h05, 32'h0}, 3);
	endtask
	task status_write_cmd(input [7:0] v);
		tx({8'h06, 32'h0}, 1);
		tx({8'h01, v, 24'h0}, 2);
	endtask
	task wr(input [15:0] ad, input [7:0] v);
		tx({8'h06, 32'h0}, 1);
		tx({8'h02, ad, v, 8'h0}, 4);
	endtask
	task wait_idle;
		for (int i = 0; i < 20; i++) begin
			status_read_cmd;
			if (r[0] === 1'b0)
				break;
		end
	endtask
	task report_and_stop;
		$display("checks %0d errors %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// Cuts a hung run short
	always @(posedge CLK) begin
		cyc++;
		if (cyc == 80000) begin
			n_errors++;
			report_and_stop;
		end
	end
	// Test sequence
	initial begin
		repeat (6) @(negedge CLK);
		RESET = 1'b0;
		#200;
		status_read_cmd;
		`CHK("reset status", es(0), r)
		tx({8'h06, 32'h0}, 1);
		status_read_cmd;
		lat = 1'b1;
		`CHK("latch set", es(0), r)
		tx({8'h04, 32'h0}, 1);
		status_read_cmd;
		lat = 1'b0;
		`CHK("latch clear", es(0), r)
		tx({8'h01, 8'h8c, 24'h0}, 2);
		status_read_cmd;
		`CHK("unlatched write", es(0), r)
		tx({8'hff, 8'h05, 24'h0}, 3);
		`CHK("unknown opcode", 1'b0, oe)
		$display("test latch done");
		a = $random(seed);
		d = $random(seed);
		wr(16'h7fff, a);
		tx({8'h03, 16'h7fff, 16'h0}, 5);
		`CHK("read while busy", 1'b0, oe)
		wait_idle;
		`CHK("write end", es(0), r)
		wr(16'h0000, d);
		wait_idle;
		tx({8'h03, 16'h7fff, 16'h0}, 4);
		`CHK("array read", a, r)
		tx({8'h03, 16'h7fff, 16'h0}, 5);
		`CHK("read wrap", d, r)
		$display("test array done");
		d = $random(seed);
		d[7] = 1'b0;
		d[3:2] = 2'h1;
		@(negedge CLK) LOCK_N = 1'b0;
		status_write_cmd(d);
		status_read_cmd;
		lat = 1'b1;
		`CHK("status busy", es(1), r)
		wait_idle;
		lat = 1'b0;
		g = d[3:2];
		`CHK("status written", es(0), r)
		wr(16'h7fff, ~a);
		wait_idle;
		tx({8'h03, 16'h7fff, 16'h0}, 4);
		`CHK("guarded write", a, r)
		status_write_cmd(8'h80);
		wait_idle;
		{lk, g, lat} = 4'h8;
		`CHK("lock set", es(0), r)
		status_write_cmd(8'h0c);
		status_read_cmd;
		lat = 1'b1;
		`CHK("hard lock", es(0), r)
		@(negedge CLK) LOCK_N = 1'b1;
		tx({8'h01, 32'h0}, 2);
		wait_idle;
		{lk, lat} = 2'h0;
		`CHK("lock pin high", es(0), r)
		$display("test protect done");
		tx({8'h06, 32'h0}, 1);
		tx({8'h01, 8'h8c, 24'h0}, 3);
		status_read_cmd;
		lat = 1'b1;
		`CHK("late deselect", es(0), r)
		sesr_spi_i.cpol = 1'b1;
		tx({8'h04, 32'h0}, 1);
		status_read_cmd;
		lat = 1'b0;
		`CHK("idle high clock", es(0), r)
		$display("test framing done");
		report_and_stop;
	end
endmodule // tb_top
